// >>> verilog/i2c_port_defines.svh
/*
 * Register offsets, field positions and reset values of the two-wire
 * serial port control block. Assumes a 12-bit APB byte address.
 */
`ifndef I2C_PORT_DEFINES_SVH
`define I2C_PORT_DEFINES_SVH

// Register byte offsets on the APB bus.
`define APB_ADDR_W          12
`define APB_DATA_W          32
`define OFS_CTRL            12'h000
`define OFS_BUF             12'h004
`define OFS_BAUD            12'h008
`define OFS_STATUS          12'h00C
`define OFS_IRQ_STAT        12'h010
`define OFS_IRQ_MASK        12'h014

// Control register fields.
`define CTRL_W              8
`define CTRL_WRITE_COLLISION_FLAG_BIT       7
`define CTRL_OVF_BIT        6
`define CTRL_EN_BIT         5
`define CTRL_CKR_BIT        4
`define CTRL_MODE_MSB       3
`define CTRL_MODE_LSB       0
`define CTRL_RST            8'h00

// Baud reload, buffer and status fields.
`define BYTE_W              8
`define BAUD_RST            8'h00
`define STAT_BUF_FULL_BIT   0
`define STAT_START_BIT      1
`define STAT_TX_BUSY_BIT    2

// Interrupt status and mask layout.
`define IRQ_W               5
`define IRQ_WRITE_COLLISION_FLAG_BIT        0
`define IRQ_OVF_BIT         1
`define IRQ_START_BIT       2
`define IRQ_STOP_BIT        3
`define IRQ_RX_BIT          4
`define IRQ_RST             5'h00

// Bus clock is four divider ticks long: two phase bits.
`define BUS_CLK_PHASE_W     2

`endif

// >>> verilog/i2c_port_pkg.sv
/*
 * Types shared by the serial port control block: the mode encodings and
 * the decode of the mode field. Assumes the defines header is present.
 */
`include "i2c_port_defines.svh"

package i2c_port_pkg;

	// Two-wire modes, coded as the mode field values that select them.
	typedef enum logic [3:0] {
		MODE_NONE      = 4'h0,
		MODE_SLV7      = 4'h6,
		MODE_SLV10     = 4'h7,
		MODE_HW_MASTER = 4'h8,
		MODE_FW_MASTER = 4'hB,
		MODE_SLV7_SS   = 4'hE,
		MODE_SLV10_SS  = 4'hF
	} mode_e;

	// Any code not listed is reserved or belongs to the SPI function.
	function automatic mode_e decode_mode(input logic [3:0] code);
		case (code)
			4'h6:    return MODE_SLV7;
			4'h7:    return MODE_SLV10;
			4'h8:    return MODE_HW_MASTER;
			4'hB:    return MODE_FW_MASTER;
			4'hE:    return MODE_SLV7_SS;
			4'hF:    return MODE_SLV10_SS;
			default: return MODE_NONE;
		endcase
	endfunction

	// Whole register state of the control block.
	typedef struct packed {
		logic [`CTRL_W-1:0]     ctrl;
		logic [`BYTE_W-1:0]     baud;
		logic [`BYTE_W-1:0]     rx_buf;
		logic [`BYTE_W-1:0]     tx_data;
		logic                   tx_load;
		logic                   buf_full;
		logic                   start_seen;
		logic [`IRQ_W-1:0]      irq_stat;
		logic [`IRQ_W-1:0]      irq_mask;
		logic [`APB_DATA_W-1:0] prdata;
	} regs_s;

endpackage

// >>> verilog/i2c_baud_divider.sv
/*
 * Bus clock divider for hardware master mode. Assumes a run level and a
 * reload value from registers on the same clock.
 */
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module i2c_baud_divider #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// Control.
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] reload,
	// Timing outputs.
	output logic                  tick,
	output logic                  bus_clk
);

	typedef struct packed {
		logic [WIDTH-1:0]              cnt;
		logic [`BUS_CLK_PHASE_W-1:0]   phase;
		logic                          tick;
	} div_s;

	div_s q;
	div_s d;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("i2c_baud_divider: WIDTH must be at least 1.");
	end

	// A tick every reload+1 cycles; four ticks make one bus clock.
	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		if (!run)
		begin
			d = '0;
		end
		else if (q.cnt >= reload)
		begin
			d.cnt = '0;
			d.tick = 1'b1;
			d.phase = q.phase + 1'b1;
		end
		else
		begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	// Registered state; synchronous reset.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;
	assign bus_clk = q.phase[`BUS_CLK_PHASE_W-1];

	property p_div_fast;
		@(posedge clk_sys) disable iff (srst)
		run && $past(run) && $past(tick) && reload == '0 |-> tick;
	endproperty
	a_div_fast: assert property (p_div_fast)
		else $error("Divider does not tick every cycle at reload zero.");

	property p_div_stop;
		@(posedge clk_sys) disable iff (srst)
		!run |=> !tick && !bus_clk;
	endproperty
	a_div_stop: assert property (p_div_stop)
		else $error("Divider kept running while stopped.");

endmodule

// >>> verilog/i2c_port_control_register.sv
/*
 * Control register, mode decode, flags and interrupts of a two-wire serial
 * port, reached over APB. Assumes a shift engine on the same clock that
 * reports direction, busy, start/stop detection and received bytes.
 */
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module i2c_port_control_register (
	// Clock and reset.
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// APB slave.
	input  wire logic [`APB_ADDR_W-1:0] paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`APB_DATA_W-1:0] pwdata,
	output logic      [`APB_DATA_W-1:0] prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Shift engine status.
	input  wire logic                   tx_dir,
	input  wire logic                   shift_busy,
	input  wire logic                   start_ok,
	input  wire logic                   rx_valid,
	input  wire logic [`BYTE_W-1:0]     rx_byte,
	input  wire logic                   start_det,
	input  wire logic                   stop_det,
	// Shift engine control.
	output logic                        tx_load,
	output logic      [`BYTE_W-1:0]     tx_data,
	output logic                        port_enable,
	output logic                        pins_to_port,
	output logic                        slave_active,
	output logic                        addr_10bit,
	output logic                        start_stop_irq_en,
	output logic                        hw_master,
	output logic                        fw_master,
	output logic                        master_tick,
	output logic                        master_scl,
	// Clock stretch drive, open drain.
	output logic                        scl_o,
	output logic                        scl_oe,
	// Interrupt.
	output logic                        irq
);

	i2c_port_pkg::regs_s q;
	i2c_port_pkg::regs_s d;
	i2c_port_pkg::mode_e mode;
	logic                div_run;

	// True for offsets that hold a register.
	function automatic logic addr_known(input logic [`APB_ADDR_W-1:0] a);
		case (a)
			`OFS_CTRL, `OFS_BUF, `OFS_BAUD, `OFS_STATUS,
			`OFS_IRQ_STAT, `OFS_IRQ_MASK: return 1'b1;
			default:                       return 1'b0;
		endcase
	endfunction

	// Mode from the stored field; a disabled port has no mode at all.
	assign mode = q.ctrl[`CTRL_EN_BIT] ?
		i2c_port_pkg::decode_mode(
			q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]) :
		i2c_port_pkg::MODE_NONE;

	// Next state: bus access first, then hardware events, so sets win.
	always_comb
	begin
		logic                 acc;
		logic                 wr;
		logic                 rd_buf;
		logic                 is_slave;
		logic                 is_master;
		logic                 ss_mode;
		logic [`IRQ_W-1:0]    ev;
		acc = psel && penable;
		wr = acc && pwrite && addr_known(paddr);
		rd_buf = acc && !pwrite && paddr == `OFS_BUF;
		is_slave = slave_active;
		is_master = hw_master || fw_master;
		ss_mode = start_stop_irq_en;
		ev = `IRQ_RST;
		d = q;
		d.tx_load = 1'b0;

		// Read data is captured in the setup cycle and held for access.
		if (psel && !penable)
		begin
			case (paddr)
				`OFS_CTRL:     d.prdata = `APB_DATA_W'(q.ctrl);
				`OFS_BUF:      d.prdata = `APB_DATA_W'(q.rx_buf);
				`OFS_BAUD:     d.prdata = `APB_DATA_W'(q.baud);
				`OFS_STATUS:
				begin
					d.prdata = '0;
					d.prdata[`STAT_BUF_FULL_BIT] = q.buf_full;
					d.prdata[`STAT_START_BIT] = q.start_seen;
					d.prdata[`STAT_TX_BUSY_BIT] = shift_busy;
				end
				`OFS_IRQ_STAT: d.prdata = `APB_DATA_W'(q.irq_stat);
				`OFS_IRQ_MASK: d.prdata = `APB_DATA_W'(q.irq_mask);
				default:       d.prdata = '0;
			endcase
		end

		// Register writes.
		if (wr)
		begin
			case (paddr)
				`OFS_CTRL:     d.ctrl = pwdata[`CTRL_W-1:0];
				`OFS_BAUD:     d.baud = pwdata[`BYTE_W-1:0];
				`OFS_IRQ_STAT: d.irq_stat = q.irq_stat &
					~pwdata[`IRQ_W-1:0];
				`OFS_IRQ_MASK: d.irq_mask = pwdata[`IRQ_W-1:0];
				`OFS_BUF:
				begin
					d.tx_data = pwdata[`BYTE_W-1:0];
					if (is_master && tx_dir)
					begin
						if (start_ok)
							d.tx_load = 1'b1;
						else
							ev[`IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
					end
					else if (is_slave && tx_dir)
					begin
						if (shift_busy)
							ev[`IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
						else
							d.tx_load = 1'b1;
					end
					// Receive mode: the write is stored only.
				end
				default: ;
			endcase
		end

		// Reading the buffer empties it.
		if (rd_buf)
			d.buf_full = 1'b0;

		// A received byte is dropped, not stored, while still unread.
		if (rx_valid && !tx_dir && mode != i2c_port_pkg::MODE_NONE)
		begin
			if (q.buf_full && !rd_buf)
				ev[`IRQ_OVF_BIT] = 1'b1;
			else
			begin
				d.rx_buf = rx_byte;
				d.buf_full = 1'b1;
				ev[`IRQ_RX_BIT] = 1'b1;
			end
		end

		// Start and stop tracking; stop ends the started state.
		if (start_det && mode != i2c_port_pkg::MODE_NONE)
			d.start_seen = 1'b1;
		else if (stop_det)
			d.start_seen = 1'b0;
		ev[`IRQ_START_BIT] = start_det && ss_mode;
		ev[`IRQ_STOP_BIT] = stop_det && ss_mode;
		if (!d.ctrl[`CTRL_EN_BIT])
			d.start_seen = 1'b0;

		// Flags are set after any software write so the set wins.
		if (ev[`IRQ_WRITE_COLLISION_FLAG_BIT])
			d.ctrl[`CTRL_WRITE_COLLISION_FLAG_BIT] = 1'b1;
		if (ev[`IRQ_OVF_BIT])
			d.ctrl[`CTRL_OVF_BIT] = 1'b1;
		d.irq_stat = d.irq_stat | ev;

		if (srst)
		begin
			d = '0;
			d.ctrl = `CTRL_RST;
			d.baud = `BAUD_RST;
			d.irq_stat = `IRQ_RST;
			d.irq_mask = `IRQ_RST;
		end
	end

	// Single state register.
	always_ff @(posedge clk_sys)
	begin
		q <= d;
	end

	// APB answers with no wait states; unmapped offsets report an error.
	assign prdata = q.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_known(paddr);

	// Mode decode outputs.
	assign port_enable = q.ctrl[`CTRL_EN_BIT];
	assign pins_to_port = q.ctrl[`CTRL_EN_BIT];
	assign slave_active = mode == i2c_port_pkg::MODE_SLV7 ||
		mode == i2c_port_pkg::MODE_SLV10 ||
		mode == i2c_port_pkg::MODE_SLV7_SS ||
		mode == i2c_port_pkg::MODE_SLV10_SS;
	assign addr_10bit = mode == i2c_port_pkg::MODE_SLV10 ||
		mode == i2c_port_pkg::MODE_SLV10_SS;
	assign start_stop_irq_en = mode == i2c_port_pkg::MODE_SLV7_SS ||
		mode == i2c_port_pkg::MODE_SLV10_SS;
	assign hw_master = mode == i2c_port_pkg::MODE_HW_MASTER;
	assign fw_master = mode == i2c_port_pkg::MODE_FW_MASTER;
	assign tx_load = q.tx_load;
	assign tx_data = q.tx_data;

	// Stretch pulls the clock low only; it never drives it high.
	assign scl_o = 1'b0;
	assign scl_oe = slave_active && !q.ctrl[`CTRL_CKR_BIT];

	// Level interrupt from any unmasked sticky event.
	assign irq = |(q.irq_stat & q.irq_mask);

	// Bus clock generator runs only in hardware master mode.
	assign div_run = hw_master;
	i2c_baud_divider #(
		.WIDTH (`BYTE_W)
	) u_div (
		.clk_sys (clk_sys),
		.srst    (srst),
		.run     (div_run),
		.reload  (q.baud),
		.tick    (master_tick),
		.bus_clk (master_scl)
	);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_write_collision_flag_master;
		psel && penable && pwrite && paddr == `OFS_BUF && hw_master &&
			tx_dir && !start_ok |=> q.ctrl[`CTRL_WRITE_COLLISION_FLAG_BIT] && !tx_load;
	endproperty
	a_write_collision_flag_master: assert property (p_write_collision_flag_master)
		else $error("Master write collision not flagged.");

	property p_write_collision_flag_slave;
		psel && penable && pwrite && paddr == `OFS_BUF && slave_active &&
			tx_dir && shift_busy |=> q.ctrl[`CTRL_WRITE_COLLISION_FLAG_BIT] && !tx_load;
	endproperty
	a_write_collision_flag_slave: assert property (p_write_collision_flag_slave)
		else $error("Slave write collision not flagged.");

	property p_write_collision_flag_rx;
		psel && penable && pwrite && paddr == `OFS_BUF && !tx_dir
			|=> !tx_load && q.ctrl[`CTRL_WRITE_COLLISION_FLAG_BIT] ==
			$past(q.ctrl[`CTRL_WRITE_COLLISION_FLAG_BIT]);
	endproperty
	a_write_collision_flag_rx: assert property (p_write_collision_flag_rx)
		else $error("Receive mode buffer write changed collision state.");

	property p_ovf;
		rx_valid && !tx_dir && port_enable && mode != 4'h0 && q.buf_full &&
			!(psel && penable && !pwrite && paddr == `OFS_BUF)
			|=> q.ctrl[`CTRL_OVF_BIT] && q.rx_buf == $past(q.rx_buf);
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("Receive overflow not flagged or byte overwritten.");

	property p_disable;
		psel && penable && pwrite && paddr == `OFS_CTRL &&
			!pwdata[`CTRL_EN_BIT] |=> (!pins_to_port && !scl_oe &&
			!hw_master) ##1 !master_tick;
	endproperty
	a_disable: assert property (p_disable)
		else $error("Port still active after disable.");

	property p_stretch;
		(slave_active && !q.ctrl[`CTRL_CKR_BIT] |-> scl_oe) and
			(hw_master || fw_master |-> !scl_oe);
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("Clock stretch drive wrong for mode.");

	property p_ss_modes;
		port_enable && q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_MSB-2] == 3'h7
			|-> slave_active && start_stop_irq_en &&
			addr_10bit == q.ctrl[`CTRL_MODE_LSB];
	endproperty
	a_ss_modes: assert property (p_ss_modes)
		else $error("Slave mode with start/stop interrupts misdecoded.");

	property p_plain_slave;
		port_enable && q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_MSB-2] == 3'h3
			|-> slave_active && !start_stop_irq_en &&
			addr_10bit == q.ctrl[`CTRL_MODE_LSB];
	endproperty
	a_plain_slave: assert property (p_plain_slave)
		else $error("Plain slave mode misdecoded.");

	property p_fw_master;
		fw_master |-> !slave_active && !hw_master && !master_tick;
	endproperty
	a_fw_master: assert property (p_fw_master)
		else $error("Firmware master left slave or divider active.");

	property p_no_mode;
		mode == i2c_port_pkg::MODE_NONE |-> !slave_active && !hw_master &&
			!fw_master && !scl_oe;
	endproperty
	a_no_mode: assert property (p_no_mode)
		else $error("Unlisted mode code selected a two-wire mode.");

	property p_start_clr;
		!port_enable |-> !q.start_seen;
	endproperty
	a_start_clr: assert property (p_start_clr)
		else $error("Start flag set while port disabled.");

	property p_reset;
		@(posedge clk_sys) disable iff (1'b0)
			srst |=> q.ctrl == `CTRL_RST && !port_enable;
	endproperty
	a_reset: assert property (p_reset)
		else $error("Control register not zero after reset.");

endmodule

// >>> tb/i2c_engine_model.sv
/*
 * Far-side shift engine model: direction, busy, received bytes, start
 * and stop events. Assumes the bench commands it on clk_sys.
 */
`timescale 1ns/1ps

module i2c_engine_model #(
	parameter int BUSY_CYC = 6
) (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// Bench commands.
	input  wire logic       c_dir,
	input  wire logic       c_ok,
	input  wire logic       c_rx,
	input  wire logic [7:0] c_byte,
	input  wire logic       c_start,
	input  wire logic       c_stop,
	// From the port.
	input  wire logic       tx_load,
	input  wire logic       scl_oe,
	// To the port.
	output logic            tx_dir,
	output logic            shift_busy,
	output logic            start_ok,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            start_det,
	output logic            stop_det,
	output logic            scl
);
	int cnt;

	// The clock line has a pull-up; the port can only pull it low.
	assign scl = !scl_oe;
	assign shift_busy = (cnt != 0);

	// A load keeps the shifter busy, so a quick second write collides.
	always @(posedge clk_sys)
	begin
		tx_dir <= c_dir;
		start_ok <= c_ok;
		rx_valid <= c_rx;
		start_det <= c_start;
		stop_det <= c_stop;
		if (srst)
		begin
			cnt <= 0;
			rx_byte <= 8'h00;
		end
		else
		begin
			rx_byte <= c_rx ? c_byte : ~rx_byte; // Idle data never looks stale.
			if (tx_load)
				cnt <= BUSY_CYC;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// >>> tb/i2c_port_control_register_bench.sv
/*
 * Self-checking bench of the serial port control block over APB.
 * Assumes the engine model stands in for the shift engine.
 */
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module i2c_port_control_register_bench;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, serr, scl, scl_o, scl_oe, irq;
	logic        c_dir = 0, c_ok = 0, c_rx = 0, c_start = 0, c_stop = 0;
	logic [7:0]  c_byte = 8'h00, b0, b1, bd, rx_byte, tx_data;
	logic        tx_dir, shift_busy, start_ok, rx_valid, start_det;
	logic        stop_det, tx_load, port_enable, pins_to_port;
	logic        slave_active, addr_10bit, start_stop_irq_en;
	logic        hw_master, fw_master, master_tick, master_scl;
	int          fail_count = 0, n_tests = 0, seed = 98448, n, k;

	// The design and its far side.
	i2c_port_control_register dut_u (.clk_sys, .srst, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .tx_dir,
		.shift_busy, .start_ok, .rx_valid, .rx_byte, .start_det,
		.stop_det, .tx_load, .tx_data, .port_enable, .pins_to_port,
		.slave_active, .addr_10bit, .start_stop_irq_en, .hw_master,
		.fw_master, .master_tick, .master_scl, .scl_o, .scl_oe, .irq);
	i2c_engine_model eng_u (.clk_sys, .srst, .c_dir, .c_ok, .c_rx,
		.c_byte, .c_start, .c_stop, .tx_load, .scl_oe, .tx_dir,
		.shift_busy, .start_ok, .rx_valid, .rx_byte, .start_det,
		.stop_det, .scl);

	// Free-running system clock, 10 ns period.
	always #5 clk_sys = ~clk_sys;

	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk_sys);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1)
		begin
			fail_count++;
			finish_test();
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask

	// One received byte, or start and stop pulses, from the far side.
	task rx(input logic [7:0] b);
		@(posedge clk_sys);
		c_rx <= 1'b1;
		c_byte <= b;
		@(posedge clk_sys);
		c_rx <= 1'b0;
		@(posedge clk_sys); // The port takes the byte one edge later.
	endtask

	task ev(input logic s, input logic p);
		@(posedge clk_sys);
		c_start <= s;
		c_stop <= p;
		@(posedge clk_sys);
		c_start <= 1'b0;
		c_stop <= 1'b0;
	endtask

	// Cycles between two rising edges of the tick or the bus clock.
	task period(input logic sel, output int p);
		int t, r;
		logic s, pv;
		pv = 1'b1;
		r = 0;
		p = 0;
		for (t = 0; t < 400 && r < 2; t++)
		begin
			@(negedge clk_sys);
			s = sel ? master_scl : master_tick;
			if (r == 1)
				p++;
			if (s && !pv)
				r++;
			pv = s;
		end
	endtask

	// Mode outputs {slave, 10-bit, start/stop irq, hw master, fw master}.
	function automatic logic [4:0] exp_mode(input logic [3:0] m);
		case (m)
			4'h6:    return 5'h10;
			4'h7:    return 5'h18;
			4'hE:    return 5'h14;
			4'hF:    return 5'h1C;
			4'h8:    return 5'h02;
			4'hB:    return 5'h01;
			default: return 5'h00;
		endcase
	endfunction

	// Watchdog against a hang anywhere in the sequence.
	initial
	begin
		#400000;
		fail_count++;
		finish_test();
	end

	// Main sequence.
	initial
	begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		rdchk(`OFS_CTRL, 32'h0);
		chk_bit(pins_to_port, 1'b0);
		apb(1'b0, 12'hFF0, 32'h0);
		chk_bit(serr, 1'b1);
		chk_reg(rd, 32'h0);
		for (k = 0; k < 32; k++)
		begin
			wr(`OFS_CTRL, {26'h0, k[4], 1'b1, k[3:0]});
			@(negedge clk_sys);
			chk_reg(32'({slave_active, addr_10bit, start_stop_irq_en,
				hw_master, fw_master}), 32'(k[4] ? exp_mode(k[3:0]) :
				5'h00));
			chk_bit(pins_to_port, k[4]);
			chk_bit(port_enable, k[4]);
		end
		for (k = 0; k < 4; k++)
		begin
			wr(`OFS_CTRL, {26'h0, 1'b1, k[0], k[1] ? 4'h8 : 4'h6});
			@(negedge clk_sys);
			chk_bit(scl_oe, !k[1] && !k[0]);
			chk_bit(scl, k[1] || k[0]);
			chk_bit(scl_o, 1'b0);
		end
		// Master transmit: a write while the bus cannot start collides.
		c_dir <= 1'b1;
		wr(`OFS_CTRL, 32'h38);
		bd = 8'($random(seed));
		wr(`OFS_BUF, {24'h0, bd});
		repeat (5) @(posedge clk_sys);
		rdchk(`OFS_CTRL, 32'hB8);
		wr(`OFS_CTRL, 32'h38);
		c_ok <= 1'b1;
		wr(`OFS_BUF, {24'h0, bd});
		@(negedge clk_sys);
		chk_bit(tx_load, 1'b1);
		chk_reg({24'h0, tx_data}, {24'h0, bd});
		rdchk(`OFS_CTRL, 32'h38);
		// Slave transmit: a second write during shifting collides.
		wr(`OFS_CTRL, 32'h36);
		repeat (10) @(posedge clk_sys);
		wr(`OFS_BUF, {24'h0, bd});
		wr(`OFS_BUF, {24'h0, ~bd});
		rdchk(`OFS_CTRL, 32'hB6);
		wr(`OFS_CTRL, 32'h36);
		repeat (10) @(posedge clk_sys);
		wr(`OFS_BUF, {24'h0, bd});
		rdchk(`OFS_CTRL, 32'h36);
		// Receive: buffer writes leave the collision flag alone.
		c_dir <= 1'b0;
		repeat (10) @(posedge clk_sys);
		wr(`OFS_IRQ_MASK, 32'h02);
		wr(`OFS_BUF, {24'h0, bd});
		rdchk(`OFS_CTRL, 32'h36);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		rx(b0);
		rx(b1);
		@(negedge clk_sys);
		chk_bit(irq, 1'b1);
		rdchk(`OFS_CTRL, 32'h76);
		rdchk(`OFS_BUF, {24'h0, b0});
		wr(`OFS_IRQ_STAT, 32'h1F);
		rx(b1);
		@(negedge clk_sys);
		chk_bit(irq, 1'b0);
		wr(`OFS_IRQ_MASK, 32'h10);
		@(negedge clk_sys);
		chk_bit(irq, 1'b1);
		rdchk(`OFS_BUF, {24'h0, b1});
		// Start and stop events, then disabling drops start seen.
		wr(`OFS_IRQ_STAT, 32'h1F);
		wr(`OFS_CTRL, 32'h3E);
		ev(1'b1, 1'b0);
		rdchk(`OFS_STATUS, 32'h2);
		ev(1'b0, 1'b1);
		rdchk(`OFS_IRQ_STAT, 32'h0C);
		ev(1'b1, 1'b0);
		wr(`OFS_CTRL, 32'h1E);
		rdchk(`OFS_STATUS, 32'h0);
		wr(`OFS_CTRL, 32'h36);
		wr(`OFS_IRQ_STAT, 32'h1F);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		rdchk(`OFS_IRQ_STAT, 32'h0);
		// Hardware master bus clock for random reload values.
		for (k = 0; k < 2; k++)
		begin
			bd = 8'(1 + ($random(seed) & 3));
			wr(`OFS_BAUD, {24'h0, bd});
			wr(`OFS_CTRL, 32'h38);
			period(1'b0, n);
			chk_reg(n, bd + 1);
			period(1'b1, n);
			chk_reg(n, 4 * (bd + 1));
		end
		// Disabling stops the bus clock generator within two cycles.
		wr(`OFS_CTRL, 32'h18);
		repeat (2) @(negedge clk_sys);
		chk_bit(master_tick, 1'b0);
		chk_bit(master_scl, 1'b0);
		finish_test();
	end
endmodule
